/* src/gpx_consts.svh */
/*
 * Constants of the sixteen-pin port: register offsets, field positions,
 * reset values, pin roles, priority groups and timing counts.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave
`define GPX_OFS_GENCTRL      8'h00
`define GPX_OFS_DIR          8'h04
`define GPX_OFS_OUT          8'h08
`define GPX_OFS_PIN          8'h0c
`define GPX_OFS_STATUS       8'h10

// Fields of general_control_reg
`define GPX_GC_EVT_BIT       0
`define GPX_GC_OSC_BIT       1
`define GPX_GC_SER_LSB       2
`define GPX_GC_SER_MSB       4
`define GPX_SERIAL_CONFIG_FIELD_SERIAL   3'h2

// Reset values
`define GPX_RST_GENCTRL      5'h00
`define GPX_RST_DIR          16'h0000
`define GPX_RST_OUT          16'h0000

// Pin roles
`define GPX_PIN_EVT          0
`define GPX_PIN_CRS          2
`define GPX_PIN_OSC          7
`define GPX_PIN_RXD          8
`define GPX_PIN_TXD          9
`define GPX_PIN_MODE         10
`define GPX_PIN_RSV          11
`define GPX_PIN_CTS          12
`define GPX_PIN_DSR          13
`define GPX_PIN_RTS          14
`define GPX_PIN_DTR          15

// Switching priority groups
`define GPX_GRP1_MASK        16'hf007
`define GPX_GRP2_MASK        16'h0f08
`define GPX_GRP3_MASK        16'h00f0

// Oscillator settling time
`define GPX_OSC_SETTLE_US    10000
`define GPX_CLK_KHZ          20000
`define GPX_OSC_SETTLE_CYC   ((`GPX_OSC_SETTLE_US * `GPX_CLK_KHZ) / 1000)
`define GPX_SETTLE_W         18
`define GPX_PEND_MAX         4'hf

`endif

/* src/gpx_pkg.sv */
/*
 * Types of the sixteen-pin port: state enumerations and the packed
 * state record. Assumes gpx_consts.svh supplies the widths.
 */
`default_nettype none
`include "gpx_consts.svh"

package gpx_pkg;

	// Power sequence of the oscillator gate
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_SLEEP,
		PWR_WAKE
	} gpx_pwr_t;

	// AHB-Lite data phase progress
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WAIT,
		BUS_END
	} gpx_bus_t;

	// Whole state of the port
	typedef struct packed {
		logic [15:0]              sync1;
		logic [15:0]              sync2;
		logic [15:0]              sync3;
		logic [15:0]              filt;
		logic                     evt_en;
		logic                     osc_en;
		logic [2:0]               ser_cfg;
		logic [15:0]              dir_req;
		logic [15:0]              out_req;
		logic [15:0]              dir_app;
		logic [15:0]              out_app;
		logic [1:0]               stage;
		gpx_pwr_t                 pwr;
		logic                     clk_low;
		logic [`GPX_SETTLE_W-1:0] settle;
		logic [3:0]               pend;
		logic [15:0]              snap;
		gpx_bus_t                 bus_ph;
		logic [7:0]               bus_addr;
		logic                     bus_wr;
		logic [31:0]              rdata;
	} gpx_state_t;

endpackage

`default_nettype wire

/* src/gpx_port.sv */
/*
 * Sixteen-pin general purpose port with special functions: event input
 * and wake trigger, carrier sense, oscillator gate and serial pins.
 * Assumes one 20 MHz clock, an AHB-Lite master as the only bus master,
 * a network engine that takes notification requests, and pins driven
 * through a pad whose output enable is active low.
 */
`default_nettype none
`include "gpx_consts.svh"

module gpx_port
	import gpx_pkg::*;
#(
	parameter int unsigned OSC_SETTLE_CYCLES = `GPX_OSC_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Pins
	input  wire logic [15:0] gpio_in_i,
	output logic      [15:0] gpio_out_o,
	output logic      [15:0] gpio_oe_n_o,
	// Network engine: status notification
	output logic             notify_req_o,
	output logic      [15:0] notify_data_o,
	input  wire logic        notify_ack_i,
	// Network engine: carrier sense
	input  wire logic        half_duplex_i,
	output logic             crs_o,
	// Power manager
	input  wire logic        sleep_req_i,
	output logic             clk_sel_low_o,
	output logic             sleep_active_o,
	// Serial controller
	input  wire logic        serial_txd_i,
	input  wire logic        serial_rts_i,
	input  wire logic        serial_dtr_i,
	output logic             serial_active_o,
	output logic             serial_rxd_o,
	output logic             serial_mode_o,
	output logic             serial_rsv_o,
	output logic             serial_cts_o,
	output logic             serial_dsr_o
);

	// Settle reload, cut to the counter width on purpose
	localparam logic [`GPX_SETTLE_W-1:0] SETTLE_LOAD = `GPX_SETTLE_W'(OSC_SETTLE_CYCLES - 1);

	gpx_state_t s_q;
	gpx_state_t s_d;

	logic        fall0;
	logic        pend_inc;
	logic        pend_dec;
	logic [15:0] stage_mask;
	logic        ser_on;
	logic        osc_level;

	// Pins switched together in one staging step
	function automatic logic [15:0] grp_mask(input logic [1:0] stage);
		case (stage)
			2'h1:    grp_mask = `GPX_GRP1_MASK;
			2'h2:    grp_mask = `GPX_GRP2_MASK;
			2'h3:    grp_mask = `GPX_GRP3_MASK;
			default: grp_mask = 16'h0000;
		endcase
	endfunction

	// Next state of the whole port
	always_comb begin
		s_d        = s_q;
		fall0      = 1'b0;
		pend_inc   = 1'b0;
		pend_dec   = 1'b0;
		stage_mask = 16'h0000;

		s_d.sync1 = gpio_in_i;
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		// Level accepted only once stages two and three agree
		for (int i = 0; i < 16; i++) begin
			if (s_q.sync2[i] == s_q.sync3[i]) begin
				s_d.filt[i] = s_q.sync3[i];
			end
		end
		// falling edge on the filtered level
		fall0 = s_q.filt[`GPX_PIN_EVT] & ~s_d.filt[`GPX_PIN_EVT];

		pend_inc = fall0 & s_q.evt_en;
		pend_dec = notify_ack_i & (s_q.pend != 4'h0);
		// one request per edge until 15 are pending; set and clear together leave the count unchanged
		if (pend_inc && !pend_dec) begin
			if (s_q.pend != `GPX_PEND_MAX) begin
				s_d.pend = s_q.pend + 4'h1;
			end
		end else if (pend_dec && !pend_inc) begin
			s_d.pend = s_q.pend - 4'h1;
		end
		// pin status captured with the event
		if (pend_inc) begin
			s_d.snap = s_d.filt;
		end

		// one priority group applied per cycle
		if (s_q.stage != 2'h0) begin
			stage_mask = grp_mask(s_q.stage);
			s_d.dir_app = (s_q.dir_app & ~stage_mask) | (s_q.dir_req & stage_mask);
			s_d.out_app = (s_q.out_app & ~stage_mask) | (s_q.out_req & stage_mask);
			s_d.stage = (s_q.stage == 2'h3) ? 2'h0 : s_q.stage + 2'h1;
		end

		// Oscillator gate and clock choice across sleep
		case (s_q.pwr)
			PWR_RUN: begin
				// low clock selected as sleep begins
				if (sleep_req_i) begin
					s_d.pwr     = PWR_SLEEP;
					s_d.clk_low = 1'b1;
				end
			end
			PWR_SLEEP: begin
				// pin 0 edge is the wake trigger
				if (fall0) begin
					s_d.pwr    = PWR_WAKE;
					s_d.settle = SETTLE_LOAD;
				end
			end
			PWR_WAKE: begin
				if (s_q.settle == '0) begin
					s_d.pwr     = PWR_RUN;
					s_d.clk_low = 1'b0;
				end else begin
					s_d.settle = s_q.settle - `GPX_SETTLE_W'(1);
				end
			end
			default: begin
				s_d.pwr     = PWR_RUN;
				s_d.clk_low = 1'b0;
			end
		endcase

		// Bus slave: one wait cycle, then the answer
		case (s_q.bus_ph)
			BUS_IDLE, BUS_END: begin
				if (hsel_i && hready_i && htrans_i[1]) begin
					s_d.bus_ph   = BUS_WAIT;
					s_d.bus_addr = haddr_i[7:0];
					s_d.bus_wr   = hwrite_i;
				end else begin
					s_d.bus_ph = BUS_IDLE;
				end
			end
			BUS_WAIT: begin
				s_d.bus_ph = BUS_END;
				if (s_q.bus_wr) begin
					case ({s_q.bus_addr[7:2], 2'b00})
						`GPX_OFS_GENCTRL: begin
							s_d.evt_en  = hwdata_i[`GPX_GC_EVT_BIT];
							s_d.osc_en  = hwdata_i[`GPX_GC_OSC_BIT];
							s_d.ser_cfg = hwdata_i[`GPX_GC_SER_MSB:`GPX_GC_SER_LSB];
						end
						`GPX_OFS_DIR: begin
							s_d.dir_req = hwdata_i[15:0];
							s_d.stage   = 2'h1;
						end
						`GPX_OFS_OUT: begin
							s_d.out_req = hwdata_i[15:0];
							s_d.stage   = 2'h1;
						end
						default: begin
							// Read-only and unmapped writes ignored
						end
					endcase
				end else begin
					case ({s_q.bus_addr[7:2], 2'b00})
						`GPX_OFS_GENCTRL: s_d.rdata = {27'h0, s_q.ser_cfg, s_q.osc_en, s_q.evt_en};
						`GPX_OFS_DIR:     s_d.rdata = {16'h0, s_q.dir_req};
						`GPX_OFS_OUT:     s_d.rdata = {16'h0, s_q.out_req};
						`GPX_OFS_PIN:     s_d.rdata = {16'h0, s_q.filt};
						`GPX_OFS_STATUS:  s_d.rdata = {24'h0, s_q.pend, 1'b0, s_q.clk_low,
							(s_q.pwr == PWR_WAKE), (s_q.pwr == PWR_SLEEP)};
						default:          s_d.rdata = 32'h0;
					endcase
				end
			end
			default: s_d.bus_ph = BUS_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q.sync1    <= 16'h0000;
			s_q.sync2    <= 16'h0000;
			s_q.sync3    <= 16'h0000;
			s_q.filt     <= 16'h0000;
			{s_q.ser_cfg, s_q.osc_en, s_q.evt_en} <= `GPX_RST_GENCTRL;
			s_q.dir_req  <= `GPX_RST_DIR;
			s_q.out_req  <= `GPX_RST_OUT;
			s_q.dir_app  <= `GPX_RST_DIR;
			s_q.out_app  <= `GPX_RST_OUT;
			s_q.stage    <= 2'h0;
			s_q.pwr      <= PWR_RUN;
			s_q.clk_low  <= 1'b0;
			s_q.settle   <= '0;
			s_q.pend     <= 4'h0;
			s_q.snap     <= 16'h0000;
			s_q.bus_ph   <= BUS_IDLE;
			s_q.bus_addr <= 8'h00;
			s_q.bus_wr   <= 1'b0;
			s_q.rdata    <= 32'h00000000;
		end else begin
			s_q <= s_d;
		end
	end

	// Bus answers: always OKAY, ready low only in the wait cycle
	assign hrdata_o    = s_q.rdata;
	assign hreadyout_o = (s_q.bus_ph != BUS_WAIT);
	assign hresp_o     = 1'b0;

	// Notification handshake, held until acknowledged
	assign notify_req_o  = (s_q.pend != 4'h0);
	assign notify_data_o = s_q.snap;

	// serial use of the upper byte
	assign ser_on = (s_q.ser_cfg == `GPX_SERIAL_CONFIG_FIELD_SERIAL);
	// gate high unless the part sleeps
	assign osc_level = (s_q.pwr != PWR_SLEEP);

	// Pin multiplexer; special functions take precedence
	always_comb begin
		// each pin from its own bits
		gpio_out_o  = s_q.out_app;
		gpio_oe_n_o = ~s_q.dir_app;
		if (s_q.evt_en) begin
			gpio_out_o[`GPX_PIN_EVT]  = 1'b0;
			gpio_oe_n_o[`GPX_PIN_EVT] = 1'b1;
		end
		// carrier sense pin held as input
		if (half_duplex_i) begin
			gpio_out_o[`GPX_PIN_CRS]  = 1'b0;
			gpio_oe_n_o[`GPX_PIN_CRS] = 1'b1;
		end
		// gate driven from the power sequence
		if (s_q.osc_en) begin
			gpio_out_o[`GPX_PIN_OSC]  = osc_level;
			gpio_oe_n_o[`GPX_PIN_OSC] = 1'b0;
		end
		if (ser_on) begin
			gpio_out_o[15:8]  = 8'h00;
			gpio_oe_n_o[15:8] = 8'hff;
			gpio_out_o[`GPX_PIN_TXD]  = serial_txd_i;
			gpio_oe_n_o[`GPX_PIN_TXD] = 1'b0;
			gpio_out_o[`GPX_PIN_RTS]  = serial_rts_i;
			gpio_oe_n_o[`GPX_PIN_RTS] = 1'b0;
			gpio_out_o[`GPX_PIN_DTR]  = serial_dtr_i;
			gpio_oe_n_o[`GPX_PIN_DTR] = 1'b0;
		end
	end

	// carrier sense only in half duplex
	assign crs_o = half_duplex_i & s_q.filt[`GPX_PIN_CRS];

	// Power status for the rest of the device
	assign clk_sel_low_o  = s_q.clk_low;
	assign sleep_active_o = (s_q.pwr != PWR_RUN);

	// Serial inputs idle at mark level when not selected
	assign serial_active_o = ser_on;
	assign serial_rxd_o    = ser_on ? s_q.filt[`GPX_PIN_RXD]  : 1'b1;
	assign serial_mode_o   = ser_on ? s_q.filt[`GPX_PIN_MODE] : 1'b1;
	assign serial_rsv_o    = ser_on ? s_q.filt[`GPX_PIN_RSV]  : 1'b1;
	assign serial_cts_o    = ser_on ? s_q.filt[`GPX_PIN_CTS]  : 1'b1;
	assign serial_dsr_o    = ser_on ? s_q.filt[`GPX_PIN_DSR]  : 1'b1;

endmodule

`default_nettype wire

/* verification/gpx_port_sva.sv */
/* Checker for the pin port: bus wait, reset levels, events, sleep, serial.
 Assumes it is bound to gpx_port and sees only its ports. */
`default_nettype none
module gpx_port_sva #(
	parameter int unsigned OSC_SETTLE_CYCLES = 16
) (
	// Clock, reset, bus
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        hsel_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hready_i,
	input wire logic        hreadyout_o,
	// Pins and special functions
	input wire logic [15:0] gpio_in_i,
	input wire logic [15:0] gpio_out_o,
	input wire logic [15:0] gpio_oe_n_o,
	input wire logic        notify_req_o,
	input wire logic [15:0] notify_data_o,
	input wire logic        notify_ack_i,
	input wire logic        half_duplex_i,
	input wire logic        crs_o,
	input wire logic        clk_sel_low_o,
	input wire logic        sleep_active_o,
	input wire logic        serial_txd_i,
	input wire logic        serial_active_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] wake_q;
	// Cycles with pin 7 high while still asleep; only meaningful with the gate on
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_q <= 32'h0;
		end else begin
			wake_q <= (sleep_active_o && gpio_out_o[7]) ? wake_q + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_reset_pins: assert property ($rose(reset_n_i) |-> gpio_oe_n_o == 16'hffff && gpio_out_o == 16'h0)
		else $error("pins not released after reset");
	chk_bus_wait: assert property (hsel_i && hready_i && htrans_i[1] |=> !hreadyout_o ##1 hreadyout_o)
		else $error("bus wait state wrong");
	chk_crs_gate: assert property (crs_o |-> half_duplex_i)
		else $error("carrier sense outside half duplex");
	chk_serial_pins: assert property (serial_active_o |-> gpio_out_o[9] == serial_txd_i && !gpio_oe_n_o[9] && gpio_oe_n_o[8])
		else $error("serial pins not routed");
	chk_notify_hold: assert property (notify_req_o && !notify_ack_i |=> notify_req_o)
		else $error("request dropped without ack");
	chk_notify_edge: assert property ($rose(notify_req_o) |-> !$past(gpio_in_i[0], 3) && notify_data_o[0] == 1'b0)
		else $error("request without low event pin");
	chk_sleep_clock: assert property ($rose(sleep_active_o) |-> clk_sel_low_o)
		else $error("sleep without low clock");
	chk_wake_settle: assert property ($fell(clk_sel_low_o) |-> wake_q >= OSC_SETTLE_CYCLES - 1)
		else $error("main clock back too early");
endmodule
bind gpx_port gpx_port_sva #(.OSC_SETTLE_CYCLES(OSC_SETTLE_CYCLES)) gpx_port_sva_inst (.*);
`default_nettype wire

/* verification/gpx_board.sv */
/* Board model: pads with pull-ups and bench-driven external levels.
 Assumes active-low output enables from the port. */
`default_nettype none
module gpx_board (
	// Port side
	input  wire logic [15:0] pad_out_i,
	input  wire logic [15:0] pad_oe_n_i,
	// External drivers
	input  wire logic [15:0] ext_en_i,
	input  wire logic [15:0] ext_val_i,
	// Pin levels
	output logic      [15:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-up holds released pins
	// Port drive wins, then external driver; contention not modelled
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
		end
	end
endmodule
`default_nettype wire

/* verification/gpx_port_tb.sv */
/* Self-checking bench for the pin port: register rows, then hand tests.
 Assumes gpx_port, gpx_board and the checker are compiled before it. */
`default_nettype none
module gpx_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic [15:0] oe; logic [15:0] o;} gpx_row_t;
	localparam int unsigned OSC = 16;
	logic        clk, rst_n, hsel, hwrite, hrdy, ack, req, hd, slp, txd, rts, dtr, crs, clo, sact, ser, rxd;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] pin, gout, goen, ndat, ext_en, ext_v;
	int          failures, n_tests, cyc, k;
	gpx_row_t    rows [6] = '{'{8'h08, 32'ha5c3, 32'ha5c3, 16'hffff, 16'h0}, '{8'h04, 32'hffff, 32'hffff, 16'h0, 16'ha5c3},
		'{8'h04, 32'h0f0f, 32'h0f0f, 16'hf0f0, 16'h0503}, '{8'h14, 32'hffff, 32'h0, 16'hf0f0, 16'h0503},
		'{8'h0c, 32'h0, 32'hf5f3, 16'hf0f0, 16'h0503}, '{8'h00, 32'hffffffe0, 32'h0, 16'hf0f0, 16'h0503}};
	logic [31:0] grp [3] = '{32'hf007, 32'hff0f, 32'hffff};
	gpx_port #(.OSC_SETTLE_CYCLES(OSC)) gpx_port_inst (.clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .gpio_in_i(pin), .gpio_out_o(gout), .gpio_oe_n_o(goen),
		.notify_req_o(req), .notify_data_o(ndat), .notify_ack_i(ack), .half_duplex_i(hd), .crs_o(crs),
		.sleep_req_i(slp), .clk_sel_low_o(clo), .sleep_active_o(sact), .serial_txd_i(txd), .serial_rts_i(rts),
		.serial_dtr_i(dtr), .serial_active_o(ser), .serial_rxd_o(rxd), .serial_mode_o(), .serial_rsv_o(),
		.serial_cts_o(), .serial_dsr_o());
	gpx_board gpx_board_inst (.pad_out_i(gout), .pad_oe_n_i(goen), .ext_en_i(ext_en), .ext_val_i(ext_v), .pin_o(pin));
	// 20 MHz clock
	always #25 clk = !clk;
	// Hang guard, far above the roughly 170 cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	// One AHB-Lite single transfer; ready sampled just before each edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		logic ok;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin
			@(negedge clk);
			ok = hrdy;
			@(posedge clk);
		end while (!ok);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(negedge clk);
			ok = hrdy;
			r = hrdata;
			@(posedge clk);
		end while (!ok);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd);
		chk(n, rd, e);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		{clk, rst_n, hsel, hwrite, ack, hd, slp, txd, rts, dtr, htrans} = 12'h0;
		{haddr, hwdata, failures, n_tests, cyc, ext_en} = 0;
		ext_v = 16'hffff;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("reset oe", 32'(goen), 32'hffff);
		rdc("reset dir", 8'h04, 32'h0);
		rdc("reset out", 8'h08, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdc("row read", rows[i].a, rows[i].r);
			chk("row oe", 32'(goen), 32'(rows[i].oe));
			chk("row out", 32'(gout & ~goen), 32'(rows[i].o));
		end
		$display("test rows done");
		wr(8'h04, 32'hffff);
		wr(8'h08, 32'h0);
		// Let all three groups settle to zero so the next step starts clean
		repeat (4) @(posedge clk);
		wr(8'h08, 32'hffff);
		foreach (grp[i]) begin
			@(negedge clk);
			chk("group", 32'(gout), grp[i]);
		end
		$display("test groups done");
		ext_en <= 16'h0001;
		for (int j = 0; j < 3; j++) begin
			if (j == 1)
				wr(8'h00, 32'h1);
			ext_v[0] <= 1'b0;
			repeat (8) @(posedge clk);
			ext_v[0] <= 1'b1;
			repeat (8) @(posedge clk);
		end
		chk("evt input", 32'(goen[0]), 32'h1);
		chk("notify data", 32'(ndat[0]), 32'h0);
		rdc("pending", 8'h10, 32'h20);
		repeat (2) begin
			ack <= 1'b1;
			@(posedge clk);
			ack <= 1'b0;
			@(posedge clk);
		end
		chk("req cleared", 32'(req), 32'h0);
		$display("test events done");
		wr(8'h00, 32'h3);
		repeat (3) @(posedge clk);
		chk("osc run", 32'({goen[7], gout[7]}), 32'h1);
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		@(negedge clk);
		chk("asleep", 32'({clo, sact, gout[7]}), 32'h6);
		ext_v[0] <= 1'b0;
		k = 0;
		while (gout[7] !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chk("wake pin", 32'({clo, gout[7]}), 32'h3);
		k = 0;
		while (clo !== 1'b0 && k < 100) begin
			@(negedge clk);
			k++;
		end
		chk("settle", 32'(k >= OSC - 1 && k <= OSC + 1), 32'h1);
		$display("test sleep done");
		{hd, rts} <= 2'h3;
		ext_en <= 16'hffff;
		ext_v <= 16'hfeff;
		wr(8'h00, 32'h8);
		repeat (6) @(posedge clk);
		chk("carrier", 32'(crs), 32'h1);
		chk("serial", 32'({goen[2], ser, rxd, gout[9], gout[14], gout[15], goen[9], goen[8]}), 32'hc9);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("rerun oe", 32'(goen), 32'hffff);
		$display("test special done");
		wrap_up();
	end
endmodule
`default_nettype wire
